// >>> logic/upc_port_config.sv
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
// Contract
// - Modify bit with non-zero header count selects alternate alignment; the code does not select it in 8-bit transmit mode.
// - Short-cell mode sends 52-byte cells with no HEC byte.
// - HEC disable puts zero into the HEC byte position.
// - HEC enabled sends the link control HEC byte.
// - Short-cell mode overrides the HEC disable bit.
// - Full-width parity gives one bit over all sixteen data lines.
// - Otherwise parity bit 0 covers low byte, bit 1 high byte.
// - Receive type 001 is frame-based, 011 cell-based, others reserved.
// - Port address all ones means unused, PHY type disregarded.
// - Parity check enable checks receive data; disabled after reset.
// - Mixed internal framer and external PHY: no upper-byte parity.
// - Parity even when sense bit clear, odd when set; odd after reset.
// - Width bit 0 gives a 16-bit path, 1 an 8-bit path.
// - Framer receive only: width bit routes tx lines 15 to 13.
// - Otherwise the internal framer ignores the width bit.
module upc_port_config
  import upc_pkg::*;
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  output logic                    irq,
  output upc_engine_cfg_type      engine_cfg,
  input  wire upc_tx_beat_type    tx_beat,
  input  wire logic               tx_valid,
  output logic                    tx_ready,
  input  wire logic [2:0]         hdlc_tx_bits,
  output upc_phy_beat_type        phy_tx,
  output logic                    phy_tx_valid,
  input  wire logic               phy_tx_ready,
  input  wire upc_phy_beat_type   phy_rx,
  input  wire logic               phy_rx_valid,
  output logic [15:0]             rx_data,
  output logic                    rx_valid,
  output logic                    rx_par_err
);

  // Parity of a byte under the selected sense: odd sense flips it.
  function automatic logic upc_par(input logic [7:0] b, input logic odd);
    upc_par = (^b) ^ odd;
  endfunction : upc_par

  logic [31:0]         config_q;
  logic [31:0]         link_q;
  logic [UPC_ST_W-1:0] status_q;
  logic [UPC_ST_W-1:0] status_d;
  logic [UPC_ST_W-1:0] mask_q;
  logic                wr_pend_q;
  logic [7:0]          wr_addr_q;
  logic [31:0]         rdata_q;
  logic                cfg_err_q;

  // Bus decode. Address phase is accepted every cycle; the slave never
  // inserts wait states, so reads are prepared from the address phase.
  wire       xfer_ok   = hsel & hready & (htrans == UPC_HTRANS_NONSEQ |
                                            htrans == UPC_HTRANS_SEQ);
  wire       rd_req    = xfer_ok & ~hwrite;
  wire       wr_req    = xfer_ok & hwrite;
  wire [7:0] rd_addr   = haddr[7:0];
  wire       wr_config = wr_pend_q & (wr_addr_q == UPC_CONFIG_ADDR);
  wire       wr_link   = wr_pend_q & (wr_addr_q == UPC_LINK_ADDR);
  wire       wr_status = wr_pend_q & (wr_addr_q == UPC_STATUS_ADDR);
  wire       wr_mask   = wr_pend_q & (wr_addr_q == UPC_MASK_ADDR);

  // Configuration fields.
  wire [1:0] hdr_cnt    = config_q[UPC_HDR_CNT_LSB +: 2];
  wire       align_mod  = config_q[UPC_ALIGN_BIT];
  wire       short_cell = config_q[UPC_SHORT_BIT];
  wire       hec_dis    = config_q[UPC_HEC_DIS_BIT];
  wire       full_par   = config_q[UPC_FULL_PAR_BIT];
  wire [2:0] rx_type    = config_q[UPC_RX_TYPE_LSB +: 3];
  wire       pchk_en    = config_q[UPC_PCHK_BIT];
  wire       odd_par    = config_q[UPC_ODD_BIT];
  wire       width_bit  = config_q[UPC_WIDTH8_BIT];
  wire [7:0] hec_byte   = link_q[UPC_HEC_BYTE_LSB +: 8];
  wire       frm_rx     = link_q[UPC_FRM_RX_BIT];
  wire       frm_tx     = link_q[UPC_FRM_TX_BIT];
  wire [UPC_PORT_W-1:0] port_addr = link_q[UPC_PORT_LSB +: UPC_PORT_W];

  // Width only shapes the external PHY path; the framer keeps its own.
  // With the framer receiving alone, the bit only routes lines 15 to 13,
  // so the external transmit path stays sixteen bits wide.
  wire tx_width8 = width_bit & ~frm_tx & ~frm_rx;
  wire rx_width8 = width_bit & ~frm_rx;
  // Framer receive with external transmit: upper tx lines are shared.
  wire split_rx  = frm_rx & ~frm_tx;
  wire split_tx  = frm_tx & ~frm_rx;
  wire hdlc_hi   = split_rx & ~width_bit;

  // Receive PHY type selection.
  wire port_unused = &port_addr;
  upc_rx_mode_type rx_mode;
  always_comb begin
    rx_mode = UPC_RX_NONE;
    if (!port_unused) begin
      if (rx_type == UPC_PHY_FRAME) begin
        rx_mode = UPC_RX_FRAME;
      end else if (rx_type == UPC_PHY_CELL) begin
        rx_mode = UPC_RX_CELL;
      end
    end
  end
  wire cfg_err = ~port_unused & (rx_mode == UPC_RX_NONE);

  assign engine_cfg.alt_align  = align_mod & ~tx_width8 &
                                 (hdr_cnt != 2'h0);
  assign engine_cfg.short_cell = short_cell;
  assign engine_cfg.hdr_cnt    = hdr_cnt;
  assign engine_cfg.width8     = tx_width8;
  assign engine_cfg.rx_mode    = rx_mode;

  // Transmit: HEC byte handling. In short-cell mode the engine places the
  // HEC alone in its own transfer, which is dropped here.
  wire       tx_drop  = tx_beat.hec_slot & short_cell;
  wire [7:0] hec_val  = hec_dis ? 8'h00 : hec_byte;
  logic [15:0] tx_word;
  always_comb begin
    tx_word = tx_beat.data;
    if (tx_beat.hec_slot && tx_beat.hec_hi) begin
      tx_word[15:8] = hec_val;
    end else if (tx_beat.hec_slot) begin
      tx_word[7:0] = hec_val;
    end
    if (tx_width8) begin
      tx_word[15:8] = 8'h00;
    end
    if (hdlc_hi) begin
      tx_word[15:13] = hdlc_tx_bits;
    end
  end

  // Upper-byte parity is meaningless when the upper lines are not the
  // external PHY's, so only the lower byte is covered then.
  wire        tx_hi_ok = ~tx_width8 & ~hdlc_hi & ~split_rx;
  wire [7:0]  tx_hi    = tx_hi_ok ? tx_word[15:8] : 8'h00;
  logic [1:0] tx_par;
  always_comb begin
    if (tx_width8) begin
      tx_par = {1'b0, upc_par(tx_word[7:0], odd_par)};
    end else if (full_par) begin
      tx_par = {1'b0, upc_par(tx_word[7:0] ^ tx_hi, odd_par)};
    end else begin
      tx_par = {tx_hi_ok & upc_par(tx_hi, odd_par),
                upc_par(tx_word[7:0], odd_par)};
    end
  end

  // One output stage; the PHY's ready stalls the engine through it.
  assign tx_ready = ~phy_tx_valid | phy_tx_ready;
  wire   tx_load  = tx_valid & tx_ready & ~tx_drop;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_tx_valid <= 1'b0;
      phy_tx       <= '0;
    end else if (tx_ready) begin
      phy_tx_valid <= tx_load;
      if (tx_load) begin
        phy_tx <= '{data: tx_word, par: tx_par};
      end
    end
  end

  // Receive parity check.
  wire        rx_hi_ok = ~rx_width8 & ~split_tx;
  wire [7:0]  rx_hi    = rx_hi_ok ? phy_rx.data[15:8] : 8'h00;
  wire        rx_lo_p  = upc_par(phy_rx.data[7:0], odd_par);
  logic       rx_bad;
  always_comb begin
    if (rx_width8) begin
      rx_bad = rx_lo_p != phy_rx.par[0];
    end else if (full_par) begin
      rx_bad = upc_par(phy_rx.data[7:0] ^ rx_hi, odd_par)
               != phy_rx.par[0];
    end else begin
      rx_bad = (rx_lo_p != phy_rx.par[0]) |
               (rx_hi_ok & (upc_par(rx_hi, odd_par) != phy_rx.par[1]));
    end
  end
  wire rx_err = phy_rx_valid & pchk_en & rx_bad;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_valid   <= 1'b0;
      rx_data    <= 16'h0000;
      rx_par_err <= 1'b0;
    end else begin
      rx_valid   <= phy_rx_valid;
      rx_par_err <= rx_err;
      if (phy_rx_valid) begin
        rx_data <= rx_width8 ? {8'h00, phy_rx.data[7:0]} : phy_rx.data;
      end
    end
  end

  // Sticky status: a new event beats a same-cycle write-one clear.
  wire [UPC_ST_W-1:0] st_set = {cfg_err & ~cfg_err_q, rx_err};
  wire [UPC_ST_W-1:0] st_clr = wr_status ? hwdata[UPC_ST_W-1:0] : '0;
  assign status_d = (status_q & ~st_clr) | st_set;
  assign irq      = |(status_q & mask_q);

  // Read data is registered from the address phase.
  logic [31:0] rd_mux;
  always_comb begin
    unique case (rd_addr)
      UPC_CONFIG_ADDR: rd_mux = config_q;
      UPC_LINK_ADDR:   rd_mux = link_q;
      UPC_STATUS_ADDR: rd_mux = {{(32-UPC_ST_W){1'b0}}, status_q};
      UPC_MASK_ADDR:   rd_mux = {{(32-UPC_ST_W){1'b0}}, mask_q};
      UPC_STATE_ADDR:  rd_mux = {26'h0, cfg_err, port_unused,
                                 tx_width8, hdlc_hi, rx_mode};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q   <= 32'h00000000;
    end else begin
      wr_pend_q <= wr_req;
      if (xfer_ok) begin
        wr_addr_q <= haddr[7:0];
      end
      if (rd_req) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_q  <= UPC_CONFIG_RESET;
      link_q    <= UPC_LINK_RESET;
      status_q  <= '0;
      mask_q    <= '0;
      cfg_err_q <= 1'b0;
    end else begin
      status_q  <= status_d;
      cfg_err_q <= cfg_err;
      if (wr_config) begin
        config_q <= hwdata & UPC_CONFIG_MASK;
      end
      if (wr_link) begin
        link_q <= hwdata & UPC_LINK_MASK;
      end
      if (wr_mask) begin
        mask_q <= hwdata[UPC_ST_W-1:0];
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

endmodule : upc_port_config

// >>> logic/upc_pkg.sv
package upc_pkg;

  // Register byte addresses on the AHB-Lite slave.
  localparam logic [7:0] UPC_CONFIG_ADDR = 8'h00;
  localparam logic [7:0] UPC_LINK_ADDR   = 8'h04;
  localparam logic [7:0] UPC_STATUS_ADDR = 8'h08;
  localparam logic [7:0] UPC_MASK_ADDR   = 8'h0c;
  localparam logic [7:0] UPC_STATE_ADDR  = 8'h10;

  // Field positions of the port configuration register.
  localparam int UPC_HDR_CNT_LSB  = 20;
  localparam int UPC_ALIGN_BIT    = 19;
  localparam int UPC_SHORT_BIT    = 18;
  localparam int UPC_HEC_DIS_BIT  = 17;
  localparam int UPC_FULL_PAR_BIT = 16;
  localparam int UPC_RX_TYPE_LSB  = 13;
  localparam int UPC_PCHK_BIT     = 12;
  localparam int UPC_ODD_BIT      = 11;
  localparam int UPC_WIDTH8_BIT   = 10;
  localparam logic [31:0] UPC_CONFIG_MASK  = 32'h003ffc00;
  localparam logic [31:0] UPC_CONFIG_RESET = 32'h00010800;

  // Field positions of the link control register.
  localparam int UPC_HEC_BYTE_LSB = 0;
  localparam int UPC_FRM_RX_BIT   = 8;
  localparam int UPC_FRM_TX_BIT   = 9;
  localparam int UPC_PORT_LSB     = 16;
  localparam int UPC_PORT_W       = 5;
  localparam logic [31:0] UPC_LINK_MASK  = 32'h001f03ff;
  localparam logic [31:0] UPC_LINK_RESET = 32'h00000000;

  // Status and mask bit positions.
  localparam int UPC_ST_PAR_ERR = 0;
  localparam int UPC_ST_CFG_ERR = 1;
  localparam int UPC_ST_W       = 2;

  // Receive PHY type codes.
  localparam logic [2:0] UPC_PHY_FRAME = 3'h1;
  localparam logic [2:0] UPC_PHY_CELL  = 3'h3;

  localparam logic [1:0] UPC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] UPC_HTRANS_SEQ    = 2'h3;

  typedef enum logic [1:0] {
    UPC_RX_NONE  = 2'b00,
    UPC_RX_FRAME = 2'b01,
    UPC_RX_CELL  = 2'b10
  } upc_rx_mode_type;

  // One transfer from the cell engine toward the PHY.
  typedef struct packed {
    logic [15:0] data;
    logic        hec_slot;
    logic        hec_hi;
  } upc_tx_beat_type;

  // One transfer on the PHY data lines with its parity lines.
  typedef struct packed {
    logic [15:0] data;
    logic [1:0]  par;
  } upc_phy_beat_type;

  // Settings the cell engine follows.
  typedef struct packed {
    logic            alt_align;
    logic            short_cell;
    logic [1:0]      hdr_cnt;
    logic            width8;
    upc_rx_mode_type rx_mode;
  } upc_engine_cfg_type;

endpackage : upc_pkg

// >>> verification/upc_chk.sv
`timescale 1ns/100ps
module upc_chk
  import upc_pkg::*;
(
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire upc_engine_cfg_type engine_cfg,
  input wire upc_tx_beat_type    tx_beat,
  input wire logic               tx_valid,
  input wire logic               tx_ready,
  input wire upc_phy_beat_type   phy_tx,
  input wire logic               phy_tx_valid,
  input wire logic               phy_tx_ready,
  input wire logic               phy_rx_valid,
  input wire logic               rx_valid,
  input wire logic               rx_par_err
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire logic take = tx_valid && tx_ready;
  wire logic drop = tx_beat.hec_slot && engine_cfg.short_cell;
  take_out_a: assert property (take && !drop |=> phy_tx_valid)
    else $error("taken beat not sent");
  short_drop_a: assert property (take && drop
    |=> !phy_tx_valid)
    else $error("HEC beat sent in short cell mode");
  stall_hold_a: assert property (phy_tx_valid && !phy_tx_ready
    |=> phy_tx_valid && $stable(phy_tx))
    else $error("stalled beat changed");
  ready_eq_a: assert property (
    tx_ready == (!phy_tx_valid || phy_tx_ready))
    else $error("tx_ready wrong");
  narrow_hi_a: assert property (phy_tx_valid && engine_cfg.width8
    |-> phy_tx.data[15:8] == 8'h00 && phy_tx.par[1] == 1'b0)
    else $error("upper lane active in 8-bit mode");
  rx_follow_a: assert property (phy_rx_valid ##1 !phy_rx_valid
    |-> rx_valid ##1 !rx_valid)
    else $error("receive beat not passed once");
  rx_err_a: assert property (rx_par_err |-> rx_valid)
    else $error("parity error without beat");
  mode_code_a: assert property (engine_cfg.rx_mode != 2'h3)
    else $error("undefined receive mode");
  align_hdr_a: assert property (engine_cfg.alt_align
    |-> engine_cfg.hdr_cnt != 2'h0 && !engine_cfg.width8)
    else $error("alignment change with no header bytes");
endmodule : upc_chk

// >>> verification/upc_phy_model.sv
`timescale 1ns/100ps
module upc_phy_model
  import upc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  output logic             phy_tx_ready,
  output upc_phy_beat_type phy_rx,
  output logic             phy_rx_valid
);
  logic [1:0] cnt_q;
  // A stall one cycle in four makes the block hold its output beat.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cnt_q <= 2'h0;
    else
      cnt_q <= cnt_q + 2'h1;
  end
  assign phy_tx_ready = (cnt_q != 2'h3);
  initial begin
    phy_rx = '0;
    phy_rx_valid = 1'b0;
  end
  task automatic send_rx(input upc_phy_beat_type b);
    @(posedge hclk);
    phy_rx <= b;
    phy_rx_valid <= 1'b1;
    @(posedge hclk);
    phy_rx <= ~b;
    phy_rx_valid <= 1'b0;
  endtask : send_rx
endmodule : upc_phy_model

// >>> verification/tb.sv
`timescale 1ns/100ps
module tb
  import upc_pkg::*;
();
  logic               hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
  logic               hwrite = 1'b0, tx_valid = 1'b0;
  logic [1:0]         htrans = 2'h0;
  logic [2:0]         hdlc_tx_bits = 3'h5;
  logic [31:0]        haddr = '0, hwdata = '0, hrdata, r;
  upc_tx_beat_type    tx_beat = '0;
  upc_engine_cfg_type engine_cfg;
  upc_phy_beat_type   phy_tx, phy_rx;
  logic               hready, hreadyout, hresp, irq, tx_ready, phy_tx_valid;
  logic               phy_tx_ready, phy_rx_valid, rx_valid, rx_par_err;
  logic [15:0]        rx_data;
  int                 err_total = 0, n_checks = 0;
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  upc_port_config i_upc_port_config (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .irq, .engine_cfg, .tx_beat, .tx_valid, .tx_ready, .hdlc_tx_bits,
    .phy_tx, .phy_tx_valid, .phy_tx_ready, .phy_rx, .phy_rx_valid, .rx_data,
    .rx_valid, .rx_par_err);
  upc_phy_model i_upc_phy_model (.hclk, .hresetn, .phy_tx_ready, .phy_rx,
    .phy_rx_valid);
  task automatic summarize();
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [17:0] fx(input logic [15:0] v, input logic o);
    return {v, 1'b0, ^v ^ o};
  endfunction : fx
  function automatic logic rdy(input int t);
    case (t)
      0: return hready;
      1: return tx_ready;
      default: return phy_tx_valid & phy_tx_ready;
    endcase
  endfunction : rdy
  // Looks just after an edge, so the answer seen holds up to the next edge.
  task automatic wt(input int t);
    int i;
    i = 0;
    #1;
    while (rdy(t) !== 1'b1 && i < 50) begin
      @(posedge hclk);
      #1;
      i++;
    end
    if (i == 50) begin
      err_total++;
      $display("Error wait %0d expected 1 seen 0", t);
      summarize();
    end
  endtask : wt
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= UPC_HTRANS_NONSEQ;
    hwrite <= w;
    wt(0);
    @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt(0);
    @(posedge hclk);
    r = hrdata;
    #1;
  endtask : bus
  task automatic send(input upc_tx_beat_type b, input logic [17:0] e,
                      input logic o);
    @(posedge hclk);
    tx_beat  <= b;
    tx_valid <= 1'b1;
    wt(1);
    @(posedge hclk);
    tx_valid <= 1'b0;
    if (o) begin
      wt(2);
      chk("phy_tx", e, phy_tx);
    end else begin
      #1;
      chk("phy_tx_valid", 0, phy_tx_valid);
    end
  endtask : send
  task automatic s_reg();
    bus(0, UPC_CONFIG_ADDR, 0);
    chk("config", 32'h00010800, r);
    chk("hresp", 0, hresp);
    bus(1, UPC_CONFIG_ADDR, 32'hffffffff);
    bus(0, UPC_CONFIG_ADDR, 0);
    chk("config", 32'h003ffc00, r);
    bus(1, 8'h40, 32'hffffffff);
    bus(0, 8'h40, 0);
    chk("unmapped", 0, r);
    bus(1, UPC_CONFIG_ADDR, 32'h00080800);
    chk("alt_align", 0, engine_cfg.alt_align);
    bus(1, UPC_CONFIG_ADDR, 32'h00180800);
    chk("alt_align", 1, engine_cfg.alt_align);
  endtask : s_reg
  task automatic s_tx();
    bus(1, UPC_LINK_ADDR, 32'h5a);
    bus(1, UPC_CONFIG_ADDR, 32'h00010800);
    send({16'h1234, 2'b00}, fx(16'h1234, 1), 1);
    send({16'h1200, 2'b10}, fx(16'h125a, 1), 1);
    bus(1, UPC_CONFIG_ADDR, 32'h00030800);
    send({16'hff34, 2'b11}, fx(16'h0034, 1), 1);
    bus(1, UPC_CONFIG_ADDR, 32'h00070800);
    send({16'h1200, 2'b10}, 0, 0);
    send({16'h7777, 2'b00}, fx(16'h7777, 1), 1);
    bus(1, UPC_CONFIG_ADDR, 32'h0);
    send({16'h1237, 2'b00}, {16'h1237, ^8'h12, ^8'h37}, 1);
    bus(1, UPC_CONFIG_ADDR, 32'h00010c00);
    send({16'hab37, 2'b00}, fx(16'h0037, 1), 1);
  endtask : s_tx
  task automatic s_rx();
    bus(1, UPC_CONFIG_ADDR, 32'h00010800);
    i_upc_phy_model.send_rx(fx(16'h00f1, 1) ^ 18'h1);
    #1;
    chk("rx_par_err", 0, rx_par_err);
    bus(1, UPC_CONFIG_ADDR, 32'h00011800);
    i_upc_phy_model.send_rx(fx(16'h00f1, 1));
    #1;
    chk("rx", 18'h200f1, {rx_valid, rx_par_err, rx_data});
    i_upc_phy_model.send_rx(fx(16'h00f1, 0));
    #1;
    chk("rx_par_err", 1, rx_par_err);
    bus(1, UPC_CONFIG_ADDR, 32'h00001c00);
    i_upc_phy_model.send_rx({16'hff0f, 2'b01});
    #1;
    chk("rx8", 18'h2000f, {rx_valid, rx_par_err, rx_data});
    bus(1, UPC_CONFIG_ADDR, 32'h00001800);
    i_upc_phy_model.send_rx({16'h1237, 2'b00});
    #1;
    chk("rx_par_err", 1, rx_par_err);
    bus(1, UPC_LINK_ADDR, 32'h200);
    i_upc_phy_model.send_rx({16'h1237, 2'b00});
    #1;
    chk("rx_par_err", 0, rx_par_err);
    chk("irq", 0, irq);
    bus(1, UPC_MASK_ADDR, 32'h1);
    chk("irq", 1, irq);
    bus(1, UPC_STATUS_ADDR, 32'h3);
    chk("irq", 0, irq);
  endtask : s_rx
  task automatic s_mode();
    logic [1:0] m;
    for (int c = 0; c < 8; c++) begin
      m = (c == 1) ? 2'h1 : (c == 3) ? 2'h2 : 2'h0;
      bus(1, UPC_CONFIG_ADDR, 32'h00010800 | (c << 13));
      chk("rx_mode", m, engine_cfg.rx_mode);
    end
    bus(0, UPC_STATUS_ADDR, 0);
    chk("status", 2, r);
    bus(1, UPC_LINK_ADDR, 32'h001f0000);
    bus(1, UPC_CONFIG_ADDR, 32'h00016800);
    chk("rx_mode", 0, engine_cfg.rx_mode);
  endtask : s_mode
  task automatic s_route();
    bus(1, UPC_LINK_ADDR, 32'h100);
    bus(1, UPC_CONFIG_ADDR, 32'h00000800);
    send({16'h0f0f, 2'b00}, {16'haf0f, 2'b01}, 1);
    bus(1, UPC_CONFIG_ADDR, 32'h00000c00);
    send({16'hab37, 2'b00}, {16'hab37, 2'b00}, 1);
    bus(0, UPC_STATE_ADDR, 0);
    chk("hdlc_route", 0, r[2]);
    chk("tx_width8", 0, r[3]);
    bus(1, UPC_LINK_ADDR, 32'h200);
    bus(0, UPC_STATE_ADDR, 0);
    chk("tx_width8", 0, r[3]);
  endtask : s_route
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    s_reg();
    s_tx();
    s_rx();
    s_mode();
    s_route();
    summarize();
  end
endmodule : tb
bind upc_port_config upc_chk i_upc_chk (.hclk, .hresetn, .engine_cfg,
  .tx_beat, .tx_valid, .tx_ready, .phy_tx, .phy_tx_valid, .phy_tx_ready,
  .phy_rx_valid, .rx_valid, .rx_par_err);
